//--- core/ipv_pkg.sv
// Purpose: Constants and types for interrupt priority and vector generation
// Assumes: 64 vector slots, four levels plus a lowest level below them
// Notes:   Level codes are two bits; the lowest level is carried separately
package ipv_pkg;

  localparam int          IPV_NUM_VEC      = 64;
  localparam int          IPV_VEC_W        = 6;
  localparam int          IPV_LVL_W        = 2;
  localparam int          IPV_ADDR_W       = 21;
  localparam int          IPV_TBL_ADDR_W   = 19;
  localparam int          IPV_BASE_W       = 13;

  // Vector ranges
  localparam logic [5:0]  IPV_VEC_CORE_LO  = 6'h02;
  localparam logic [5:0]  IPV_VEC_CORE_HI  = 6'h05;
  localparam logic [5:0]  IPV_VEC_DBG_LO   = 6'h06;
  localparam logic [5:0]  IPV_VEC_DBG_HI   = 6'h0a;
  localparam logic [5:0]  IPV_VEC_SWI2     = 6'h0b;
  localparam logic [5:0]  IPV_VEC_SWI1     = 6'h0c;
  localparam logic [5:0]  IPV_VEC_SWI0     = 6'h0d;
  localparam logic [5:0]  IPV_VEC_LOW_VOLT = 6'h0f;
  localparam logic [5:0]  IPV_VEC_PLL      = 6'h10;
  localparam logic [5:0]  IPV_VEC_PERI_LO  = 6'h11;
  localparam logic [5:0]  IPV_VEC_PERI_HI  = 6'h3e;
  localparam logic [5:0]  IPV_VEC_LOWEST   = 6'h3f;
  localparam logic [5:0]  IPV_VEC_RESET    = 6'h00;
  localparam logic [5:0]  IPV_VEC_WDOG     = 6'h01;

  // Reserved slots: 14, 30-31, 36-39, 49-52
  localparam logic [63:0] IPV_RSVD_MASK    = 64'h001e_00f0_c000_4000;
  // Never requested through the priority tree: reset, watchdog, lowest
  localparam logic [63:0] IPV_FIXED_MASK   = 64'h8000_0000_0000_0003;

  // Level limits
  localparam logic [1:0]  IPV_LVL_0        = 2'h0;
  localparam logic [1:0]  IPV_LVL_1        = 2'h1;
  localparam logic [1:0]  IPV_LVL_2        = 2'h2;
  localparam logic [1:0]  IPV_LVL_3        = 2'h3;

  // Table base reset value: entries 0 and 1 land on reset and watchdog entry
  localparam logic [12:0] IPV_BASE_RST     = 13'h0000;
  localparam logic [20:0] IPV_RESET_ADDR   = 21'h00_0000;
  localparam logic [20:0] IPV_WDOG_ADDR    = 21'h00_0002;

endpackage : ipv_pkg

//--- core/ipv_level_map.sv
// Purpose: Effective priority level of one vector slot
// Assumes: Software level code arrives unclamped
// Notes:   Pure combinational; clamps codes into the range the slot allows
`timescale 1ns/1ps
module ipv_level_map
  import ipv_pkg::*;
(
  input  wire logic [5:0] vec_num,
  input  wire logic [1:0] sw_level,
  output logic      [1:0] eff_level
);

  wire in_core  = (vec_num >= IPV_VEC_CORE_LO) && (vec_num <= IPV_VEC_CORE_HI);
  wire in_dbg   = (vec_num >= IPV_VEC_DBG_LO) && (vec_num <= IPV_VEC_DBG_HI);
  wire in_mid   = (vec_num == IPV_VEC_LOW_VOLT) || (vec_num == IPV_VEC_PLL);
  wire in_peri  = (vec_num >= IPV_VEC_PERI_LO) && (vec_num <= IPV_VEC_PERI_HI);

  // A code of 0 on a 1-3 source is raised to 1 rather than dropping the source
  wire [1:0] lvl_1_3 = (sw_level == IPV_LVL_0) ? IPV_LVL_1 : sw_level;
  // A code of 3 on a 0-2 source is lowered to 2
  wire [1:0] lvl_0_2 = (sw_level == IPV_LVL_3) ? IPV_LVL_2 : sw_level;

  always_comb begin
    if (in_core)
      eff_level = IPV_LVL_3;
    else if (in_dbg || in_mid)
      eff_level = lvl_1_3;
    else if (in_peri)
      eff_level = lvl_0_2;
    else if (vec_num == IPV_VEC_SWI2)
      eff_level = IPV_LVL_2;
    else if (vec_num == IPV_VEC_SWI1)
      eff_level = IPV_LVL_1;
    else
      eff_level = IPV_LVL_0;
  end

endmodule // ipv_level_map

//--- core/ipv_resolver.sv
// Purpose: Picks the winning interrupt request and forms its fetch address
// Assumes: Requests are level signals from logic on clk; levels are static-ish
// Notes:   Result is registered, one cycle behind the requests
//
// Behaviour
// - Higher priority level always served first
// - Same level: smallest vector number wins
// - Programmable sources use software assigned level
// - Fetch address is table base plus offset
// - Chip reset vector 0, watchdog vector 1
// - Core exceptions 2-5 fixed at level 3
// - Debug events 6-10 take levels 1-3
// - Vectors 15 and 16 take levels 1-3
// - Peripheral vectors 17-62 take levels 0-2
// - Vector 63 wins only when nothing else
// - Two words per entry; 19-bit table addresses
// - Reset base makes entries 0-1 match reset
`timescale 1ns/1ps
module ipv_resolver
  import ipv_pkg::*;
#(
  parameter int NUM_VEC = IPV_NUM_VEC
) (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic [NUM_VEC-1:0]        irq_req,
  input  wire logic [2*NUM_VEC-1:0]      irq_level,
  input  wire logic [IPV_BASE_W-1:0]     vector_table_base,
  input  wire logic                      chip_reset_fetch,
  input  wire logic                      wdog_reset_fetch,
  output logic                           irq_valid,
  output logic [IPV_VEC_W-1:0]           irq_vector,
  output logic [IPV_LVL_W-1:0]           irq_active_level,
  output logic                           irq_lowest,
  output logic [IPV_ADDR_W-1:0]          fetch_addr
);

  // ----------------------------------------------------------------------
  // Level decode and request gating
  // ----------------------------------------------------------------------
  logic [1:0]         eff_lvl [NUM_VEC];
  logic [NUM_VEC-1:0] req_ok;

  // Reserved slots and fixed-entry slots are cut off regardless of wiring
  assign req_ok = irq_req & ~IPV_RSVD_MASK[NUM_VEC-1:0]
                          & ~IPV_FIXED_MASK[NUM_VEC-1:0];

  for (genvar g = 0; g < NUM_VEC; g++) begin : g_lvl
    ipv_level_map u_map (
      .vec_num   (6'(g)),
      .sw_level  (irq_level[2*g +: 2]),
      .eff_level (eff_lvl[g])
    );
  end

  // ----------------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------------
  // Scanning from the top down lets the lowest index overwrite on a tie
  function automatic logic [IPV_VEC_W:0] pick_lowest(input logic [NUM_VEC-1:0] v);
    logic [IPV_VEC_W:0] r;
    r = '0;
    for (int i = NUM_VEC-1; i >= 0; i--)
      if (v[i])
        r = {1'b1, 6'(i)};
    return r;
  endfunction

  logic [NUM_VEC-1:0] at_lvl [4];
  always_comb begin
    for (int l = 0; l < 4; l++)
      for (int i = 0; i < NUM_VEC; i++)
        at_lvl[l][i] = req_ok[i] && (eff_lvl[i] == 2'(l));
  end

  wire [IPV_VEC_W:0] win3 = pick_lowest(at_lvl[3]);
  wire [IPV_VEC_W:0] win2 = pick_lowest(at_lvl[2]);
  wire [IPV_VEC_W:0] win1 = pick_lowest(at_lvl[1]);
  wire [IPV_VEC_W:0] win0 = pick_lowest(at_lvl[0]);
  wire               low_req = irq_req[IPV_VEC_LOWEST];

  logic                 win_any;
  logic [IPV_VEC_W-1:0] win_vec;
  logic [1:0]           win_lvl;
  logic                 win_low;

  always_comb begin
    win_any = 1'b1;
    win_low = 1'b0;
    win_vec = '0;
    win_lvl = IPV_LVL_0;
    if (chip_reset_fetch) begin
      win_vec = IPV_VEC_RESET;
      win_lvl = IPV_LVL_3;
    end else if (wdog_reset_fetch) begin
      win_vec = IPV_VEC_WDOG;
      win_lvl = IPV_LVL_3;
    end else if (win3[IPV_VEC_W]) begin
      win_vec = win3[IPV_VEC_W-1:0];
      win_lvl = IPV_LVL_3;
    end else if (win2[IPV_VEC_W]) begin
      win_vec = win2[IPV_VEC_W-1:0];
      win_lvl = IPV_LVL_2;
    end else if (win1[IPV_VEC_W]) begin
      win_vec = win1[IPV_VEC_W-1:0];
      win_lvl = IPV_LVL_1;
    end else if (win0[IPV_VEC_W]) begin
      win_vec = win0[IPV_VEC_W-1:0];
      win_lvl = IPV_LVL_0;
    end else if (low_req) begin
      win_vec = IPV_VEC_LOWEST;
      win_low = 1'b1;
    end else begin
      win_any = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Address formation
  // ----------------------------------------------------------------------
  // Entries are two words wide; the base supplies bits above the table index.
  // Table addresses carry 19 bits, so the top bits of fetch_addr stay zero.
  // The table contents (jumps in entries 0-1, subroutine calls elsewhere)
  // are software's job; this block only points at them.
  wire [IPV_TBL_ADDR_W-1:0] tbl_off  = IPV_TBL_ADDR_W'({win_vec, 1'b0});
  wire [IPV_TBL_ADDR_W-1:0] tbl_base = IPV_TBL_ADDR_W'({vector_table_base, 7'h00});
  wire [IPV_TBL_ADDR_W-1:0] tbl_sum  = tbl_base + tbl_off;
  // With the base at reset value, entries 0 and 1 equal the reset addresses
  wire [IPV_ADDR_W-1:0]     addr_nxt = IPV_ADDR_W'(tbl_sum);

  // ----------------------------------------------------------------------
  // Next values of the result registers
  // ----------------------------------------------------------------------
  wire                  valid_nxt = win_any;
  wire [IPV_VEC_W-1:0]  vec_nxt   = win_vec;
  wire [1:0]            lvl_nxt   = win_lvl;
  wire                  low_nxt   = win_low;

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------
  logic                 valid_r;
  logic [IPV_VEC_W-1:0] vec_r;
  logic [1:0]           lvl_r;
  logic                 low_r;
  logic [IPV_ADDR_W-1:0] addr_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      valid_r <= 1'b0;
      vec_r   <= IPV_VEC_RESET;
      lvl_r   <= IPV_LVL_0;
      low_r   <= 1'b0;
      addr_r  <= IPV_RESET_ADDR;
    end else begin
      valid_r <= valid_nxt;
      vec_r   <= vec_nxt;
      lvl_r   <= lvl_nxt;
      low_r   <= low_nxt;
      addr_r  <= addr_nxt;
    end
  end

  assign irq_valid        = valid_r;
  assign irq_vector       = vec_r;
  assign irq_active_level = lvl_r;
  assign irq_lowest       = low_r;
  assign fetch_addr       = addr_r;

endmodule // ipv_resolver

//--- verif/ipv_resolver_monitor.sv
// Purpose: Port checks for the interrupt resolver
// Assumes: One clock, synchronous active-low reset
// Notes:   Results lag the sampled inputs by one edge
`timescale 1ns/1ps
module ipv_resolver_monitor
  import ipv_pkg::*;
#(
  parameter int NUM_VEC = IPV_NUM_VEC
) (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic [NUM_VEC-1:0]    irq_req,
  input wire logic [2*NUM_VEC-1:0]  irq_level,
  input wire logic [IPV_BASE_W-1:0] vector_table_base,
  input wire logic                  chip_reset_fetch,
  input wire logic                  wdog_reset_fetch,
  input wire logic                  irq_valid,
  input wire logic [IPV_VEC_W-1:0]  irq_vector,
  input wire logic [IPV_LVL_W-1:0]  irq_active_level,
  input wire logic                  irq_lowest,
  input wire logic [IPV_ADDR_W-1:0] fetch_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Live requests only: reserved and fixed slots never compete
  wire logic [63:0] live_req = irq_req & ~IPV_RSVD_MASK & ~IPV_FIXED_MASK;
  wire logic        no_fetch = !chip_reset_fetch && !wdog_reset_fetch;
  // First edge after release still shows cleared outputs
  sequence s_live; $past(reset_n); endsequence
  property p_reset; $past(!reset_n) |-> !irq_valid && fetch_addr == '0; endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_chip; s_live ##0 chip_reset_fetch |=> irq_valid && irq_vector == IPV_VEC_RESET
    && irq_active_level == IPV_LVL_3; endproperty
  a_chip: assert property (p_chip) else $error("chip reset fetch lost");
  property p_wdog; s_live ##0 wdog_reset_fetch && !chip_reset_fetch |=> irq_valid
    && irq_vector == IPV_VEC_WDOG; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog fetch lost");
  property p_core; s_live ##0 no_fetch && irq_req[2] |=> irq_vector == IPV_VEC_CORE_LO
    && irq_active_level == IPV_LVL_3; endproperty
  a_core: assert property (p_core) else $error("core exception not on top");
  property p_lowest; s_live ##0 no_fetch && live_req == '0 && irq_req[63] |=> irq_lowest
    && irq_vector == IPV_VEC_LOWEST; endproperty
  a_lowest: assert property (p_lowest) else $error("lowest source not served");
  property p_idle; s_live ##0 no_fetch && live_req == '0 && !irq_req[63]
    |=> !irq_valid; endproperty
  a_idle: assert property (p_idle) else $error("winner from nothing");
  property p_addr; irq_valid |-> fetch_addr == {2'h0, 19'({$past(vector_table_base), 7'h00}
    + {irq_vector, 1'b0})}; endproperty
  a_addr: assert property (p_addr) else $error("fetch address wrong");
  property p_lowlvl; irq_lowest |-> irq_active_level == IPV_LVL_0
    && irq_vector == 6'h3f; endproperty
  a_lowlvl: assert property (p_lowlvl) else $error("lowest flag mismatch");
  // Code 3 on the first debug slot beats every lower level when no exception waits
  property p_dbg; s_live ##0 no_fetch && live_req[5:2] == '0 && irq_req[6]
    && irq_level[13:12] == IPV_LVL_3 |=> irq_vector == IPV_VEC_DBG_LO
    && irq_active_level == IPV_LVL_3; endproperty
  a_dbg: assert property (p_dbg) else $error("debug source level ignored");
  // Peripheral slots never reach the top level, whatever code they carry
  property p_peri; irq_valid && irq_vector >= IPV_VEC_PERI_LO && irq_vector <= IPV_VEC_PERI_HI
    |-> irq_active_level != IPV_LVL_3; endproperty
  a_peri: assert property (p_peri) else $error("peripheral above its range");
endmodule // ipv_resolver_monitor

bind ipv_resolver ipv_resolver_monitor #(.NUM_VEC(NUM_VEC)) i_mon (.clk(clk), .reset_n(reset_n),
  .irq_req(irq_req), .irq_level(irq_level), .vector_table_base(vector_table_base),
  .chip_reset_fetch(chip_reset_fetch), .wdog_reset_fetch(wdog_reset_fetch),
  .irq_valid(irq_valid), .irq_vector(irq_vector), .irq_active_level(irq_active_level),
  .irq_lowest(irq_lowest), .fetch_addr(fetch_addr));

//--- verif/ipv_source_model.sv
// Purpose: Request sources and core-side fetch controls
// Assumes: Caller steps just after a rising edge
// Notes:   Requests are levels held until changed
`timescale 1ns/1ps
module ipv_source_model (
  output logic [63:0]  irq_req,
  output logic [127:0] irq_level,
  output logic [12:0]  vector_table_base,
  output logic         chip_reset_fetch,
  output logic         wdog_reset_fetch
);
  // Table contents are left to software; only entry addresses matter here
  task automatic post(input logic [63:0] rq, input logic [127:0] lv, input logic [12:0] bs,
                      input logic cr, input logic wr);
    irq_req           = rq;
    irq_level         = lv;
    vector_table_base = bs;
    chip_reset_fetch  = cr;
    wdog_reset_fetch  = wr;
  endtask
endmodule // ipv_source_model

//--- verif/interrupt_priority_vectoring_tb.sv
// Purpose: Self-checking bench for the interrupt resolver
// Assumes: Inputs move 1 ns after a rising edge
// Notes:   Model recomputes the winner every cycle
`timescale 1ns/1ps
module interrupt_priority_vectoring_tb;
  import ipv_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, chip_reset_fetch, wdog_reset_fetch, irq_valid, irq_lowest;
  logic [63:0] irq_req;
  logic [127:0] irq_level;
  logic [12:0] vector_table_base;
  logic [5:0] irq_vector;
  logic [1:0] irq_active_level;
  logic [20:0] fetch_addr;
  int miscompares = 0, cmp_count = 0;
  always #2.5 clk = ~clk;
  ipv_source_model i_src (.irq_req(irq_req), .irq_level(irq_level),
    .vector_table_base(vector_table_base), .chip_reset_fetch(chip_reset_fetch),
    .wdog_reset_fetch(wdog_reset_fetch));
  ipv_resolver i_dut (.clk(clk), .reset_n(reset_n), .irq_req(irq_req), .irq_level(irq_level),
    .vector_table_base(vector_table_base), .chip_reset_fetch(chip_reset_fetch),
    .wdog_reset_fetch(wdog_reset_fetch), .irq_valid(irq_valid), .irq_vector(irq_vector),
    .irq_active_level(irq_active_level), .irq_lowest(irq_lowest), .fetch_addr(fetch_addr));
  // Effective level of slot i with code c; -2 means the slot never competes
  function automatic int lvl_of(int i, int c);
    if (i < 2 || i == 14 || i == 30 || i == 31 || (i >= 36 && i <= 39) || (i >= 49 && i <= 52))
      return -2;
    if (i <= 5) return 3;
    if (i <= 10 || i == 15 || i == 16) return (c == 0) ? 1 : c;
    if (i <= 13) return 13 - i;
    if (i == 63) return -1;
    return (c == 3) ? 2 : c;
  endfunction
  task automatic check_cycle();
    int v = 0;
    int best = -2;
    logic [30:0] exp, got;
    @(posedge clk);
    #1;
    for (int i = 0; i < 64; i++) if (irq_req[i] && lvl_of(i, int'(irq_level[2*i+:2])) > best) begin
      best = lvl_of(i, int'(irq_level[2*i+:2]));
      v = i;
    end
    if (wdog_reset_fetch) begin v = 1; best = 3; end
    if (chip_reset_fetch) begin v = 0; best = 3; end
    exp = {best > -2, 6'(v), 2'(best < 0 ? 0 : best), best == -1,
           21'((int'(vector_table_base) * 128 + 2 * v) % 524288)};
    got = {irq_valid, irq_vector, irq_active_level, irq_lowest, fetch_addr};
    if (!reset_n) exp = '0;
    else if (!exp[30]) begin exp[29:0] = '0; got[29:0] = '0; end
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
  initial begin
    logic q;
    logic [20:0] ra;
    void'($urandom(32'h1aa4));
    i_src.post('0, '0, '0, 1'b0, 1'b0);
    repeat (10) @(posedge clk);
    #1;
    reset_n = 1'b1;
    // Each slot alone, then each beside the lowest source
    for (int i = 0; i < 128; i++) begin
      i_src.post((64'h1 << i[5:0]) | {i[6], 63'h0}, {4{$urandom}}, 13'(i * 37), 1'b0, 1'b0);
      check_cycle();
    end
    // Base at its reset value: entries 0 and 1 fall on the reset addresses
    for (int k = 0; k < 2; k++) begin
      ra = (k == 0) ? IPV_RESET_ADDR : IPV_WDOG_ADDR;
      i_src.post({$urandom, $urandom}, {4{$urandom}}, IPV_BASE_RST, k == 0, k == 1);
      check_cycle();
      cmp_count++;
      if (fetch_addr !== ra) begin
        miscompares++;
        $display("unexpected at %0t: got %h expected %h", $time, fetch_addr, ra);
      end
    end
    // Dense and sparse mixes with a reset in mid-run
    for (int n = 0; n < 400; n++) begin
      q = (n >= 200 && n <= 203);
      reset_n = (n < 200 || n > 202);
      i_src.post(q ? 64'h0 : ({$urandom, $urandom} & {$urandom, $urandom}
        & ((n % 2) ? {$urandom, $urandom} & {$urandom, $urandom} : '1)), {4{$urandom}},
        13'($urandom), !q && ($urandom % 16) == 0, !q && ($urandom % 8) == 0);
      check_cycle();
    end
    give_verdict();
  end
endmodule // interrupt_priority_vectoring_tb
